// File: rtl/nv_access_ctrl.sv
// Purpose: cpu-side access controller for a byte-wide data eeprom array
// Assumes: io port, flash busy, gie and array data are on clk_i; rc_osc_i is foreign
// Notes: a started program cycle survives reset and finishes on its own
// Summary of operation
// RQ1: 12-bit linear byte address split over low and high registers, software loads it.
// RQ2: data register supplies the write byte and holds the byte fetched by a read.
// RQ3: mode 00 erase+write, 01 erase only, 10 write only, 11 reserved.
// RQ4: mode field writes are ignored while programming is busy.
// RQ5: reset returns mode to 00 unless a program cycle is still running.
// RQ6: ready interrupt holds while enabled, global enable set and programming idle.
// RQ7: master arm bit clears itself four cycles after software sets it.
// RQ8: programming starts only if strobe is set while armed; otherwise nothing happens.
// RQ9: software waits idle, arms with strobe zero, then sets strobe within four cycles.
// RQ10: no programming starts while the cpu is writing flash.
// RQ11: self-programming software waits for flash busy clear before an eeprom write.
// RQ12: busy strobe clears when the write time has elapsed, for polling.
// RQ13: launching a write stalls the cpu for two cycles.
// RQ14: read strobe fetches the addressed byte into the data register at once.
// RQ15: a read stalls the cpu for four cycles.
// RQ16: while busy, reads and address register writes are refused.
// RQ17: write time counts rc oscillator cycles, 26368 for a full write.
// RQ18: software keeps interrupts off so the arm window does not expire.
// RQ19: registers decode at io address and io+0x20; low range allows bit set/clear.
// RQ20: software writes zero to reserved bits and never writes reserved addresses.
// RQ21: reserved mode performs no array change when the strobe is set.
`timescale 1ns/1ps
`default_nettype none
module nv_access_ctrl
  import nv_access_pkg::*;
#(
  parameter int WRITE_OSC_CYCLES = FULL_WRITE_OSC
) (
  input wire logic clk_i, // cpu clock
  input wire logic rstn_i, // sync reset, active low
  input wire logic ce_i, // clock enable, freezes state
  input wire logic [7:0] io_addr_i, // io or data-space address
  input wire logic io_wr_i, // byte write strobe
  input wire logic io_rd_i, // byte read strobe
  input wire logic [7:0] io_wdata_i, // write byte
  input wire logic bit_set_i, // single-bit set, low range only
  input wire logic bit_clr_i, // single-bit clear, low range only
  input wire logic [2:0] bit_sel_i, // bit index for set/clear
  input wire logic global_irq_en_i, // cpu global interrupt enable
  input wire logic flash_selfprog_busy_i, // cpu flash write busy
  input wire logic rc_osc_i, // calibrated rc oscillator
  input wire logic [7:0] arr_rdata_i, // array read byte, sampled in the cycle arr_read_o is high
  output logic [7:0] io_rdata_o, // read byte, cycle after io_rd_i
  output logic cpu_stall_o, // halt the cpu
  output logic irq_o, // eeprom ready interrupt
  output logic [ADDR_W-1:0] arr_addr_o, // array byte address
  output logic [7:0] arr_wdata_o, // array write byte
  output logic arr_read_o, // array read pulse
  output logic arr_erase_o, // erase pulse at program start
  output logic arr_write_o, // write pulse at program start
  output logic arr_busy_o // array program cycle running
);
  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_PROG = 1'b1} prog_state_e;

  localparam logic [OSC_W-1:0] FULL_LOAD = OSC_W'(WRITE_OSC_CYCLES);
  localparam logic [OSC_W-1:0] SPLIT_LOAD =
    OSC_W'((WRITE_OSC_CYCLES * SPLIT_TIME_US) / FULL_TIME_US);

  prog_state_e state_r, state_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [7:0] data_r, data_nxt;
  logic [1:0] mode_r, mode_nxt;
  logic rie_r, rie_nxt;
  logic [2:0] arm_r, arm_nxt;
  logic [OSC_W-1:0] osc_r, osc_nxt;
  logic [2:0] stall_r, stall_nxt;
  logic rd_pend_r, rd_pend_nxt;
  logic [7:0] rdata_nxt;
  logic erase_nxt, write_nxt, irq_nxt;
  logic osc_s1_r, osc_s2_r, osc_s3_r;
  logic osc_tick;
  logic hit_ctl, hit_dat, hit_lo, hit_hi, bit_op, wr_any;
  logic [7:0] ctl_cur, ctl_new, bit_mask;
  logic busy, start_ok, read_ok;

  // oscillator enters through two flops; the second and its delayed copy in a third feed the edge detect
  always_ff @(posedge clk_i) begin
    if (!rstn_i && ce_i) begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
    end else if (ce_i) begin
      osc_s1_r <= rc_osc_i;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
    end
  end
  assign osc_tick = osc_s2_r & ~osc_s3_r; // one rc cycle seen [RQ17]

  // address decode at io address or its data-space alias
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off) || (a == off + IO_ALIAS);
  endfunction : hit

  always_comb begin
    hit_ctl = hit(io_addr_i, OFF_CONTROL); // [RQ19]
    hit_dat = hit(io_addr_i, OFF_DATA); // [RQ19]
    hit_lo = hit(io_addr_i, OFF_ADDR_LO); // [RQ19]
    hit_hi = hit(io_addr_i, OFF_ADDR_HI); // [RQ19]
    bit_op = (bit_set_i | bit_clr_i) && (io_addr_i <= IO_BIT_TOP); // [RQ19]
    wr_any = io_wr_i | bit_op;
    bit_mask = 8'h01 << bit_sel_i;
    busy = (state_r == ST_PROG);
    ctl_cur = {2'h0, mode_r, rie_r, (arm_r != 3'h0), busy, 1'b0};
    // single-bit ops touch only the chosen bit; the read strobe reads back as zero, the program strobe as busy
    if (bit_set_i) begin
      ctl_new = ctl_cur | bit_mask;
    end else if (bit_clr_i) begin
      ctl_new = ctl_cur & ~bit_mask;
    end else begin
      ctl_new = io_wdata_i;
    end
    start_ok = wr_any && hit_ctl && ctl_new[PROG_BIT] && (arm_r != 3'h0) && !busy
               && !flash_selfprog_busy_i && (mode_r != MODE_RESERVED); // [RQ8] [RQ10] [RQ21]
    read_ok = wr_any && hit_ctl && ctl_new[READ_BIT] && !busy; // [RQ16]
  end

  // register file next values
  always_comb begin
    addr_nxt = addr_r;
    data_nxt = data_r;
    mode_nxt = mode_r;
    rie_nxt = rie_r;
    arm_nxt = (arm_r != 3'h0) ? arm_r - 3'h1 : 3'h0; // self-clears after four [RQ7]
    rd_pend_nxt = read_ok;
    if (wr_any && hit_lo && !busy) begin
      addr_nxt[7:0] = bit_op ? addr_r[7:0] : io_wdata_i; // frozen while busy [RQ1] [RQ16]
    end
    if (wr_any && hit_hi && !busy) begin
      addr_nxt[ADDR_W-1:8] = io_wdata_i[ADDR_W-9:0]; // [RQ1] [RQ16]
    end
    if (wr_any && hit_dat) begin
      data_nxt = io_wdata_i; // [RQ2]
    end
    if (rd_pend_r) begin
      data_nxt = arr_rdata_i; // fetched byte lands inside the stall [RQ2] [RQ14]
    end
    if (wr_any && hit_ctl) begin
      if (!busy) begin
        mode_nxt = ctl_new[MODE_LSB +: 2]; // ignored while busy [RQ4] [RQ3]
      end
      rie_nxt = ctl_new[RIE_BIT];
      if (ctl_new[ARM_BIT] && !ctl_new[PROG_BIT] && (arm_r == 3'h0)) begin
        arm_nxt = ARM_CYCLES; // arm only with strobe written zero [RQ7]
      end else if (!ctl_new[ARM_BIT]) begin
        arm_nxt = 3'h0;
      end
    end
  end

  // program sequencer: busy until the rc count runs out
  always_comb begin
    state_nxt = state_r;
    osc_nxt = osc_r;
    erase_nxt = 1'b0;
    write_nxt = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (start_ok) begin
          state_nxt = ST_PROG;
          osc_nxt = (mode_r == MODE_ATOMIC) ? FULL_LOAD : SPLIT_LOAD; // [RQ3] [RQ17]
          erase_nxt = (mode_r != MODE_WRITE);
          write_nxt = (mode_r != MODE_ERASE);
        end
      end
      ST_PROG: begin
        if (osc_tick) begin
          if (osc_r <= OSC_W'(1)) begin
            state_nxt = ST_IDLE; // strobe reads zero when time is up [RQ12]
            osc_nxt = '0;
          end else begin
            osc_nxt = osc_r - OSC_W'(1);
          end
        end
      end
    endcase
  end

  // cpu stall counter and outputs
  always_comb begin
    stall_nxt = (stall_r != 3'h0) ? stall_r - 3'h1 : 3'h0;
    if (start_ok) begin
      stall_nxt = WR_STALL_CYCLES; // [RQ13]
    end else if (read_ok) begin
      stall_nxt = RD_STALL_CYCLES; // [RQ15]
    end
    irq_nxt = rie_nxt && global_irq_en_i && (state_nxt == ST_IDLE); // level irq [RQ6]
    rdata_nxt = RESET_BYTE;
    if (io_rd_i) begin
      if (hit_ctl) rdata_nxt = ctl_cur;
      else if (hit_dat) rdata_nxt = data_r;
      else if (hit_lo) rdata_nxt = addr_r[7:0];
      else if (hit_hi) rdata_nxt = {4'h0, addr_r[ADDR_W-1:8]};
    end
  end

  // registers; a running program cycle and its mode survive reset
  always_ff @(posedge clk_i) begin
    if (!rstn_i && ce_i) begin
      if (state_r != ST_PROG) begin
        mode_r <= MODE_RESET; // [RQ5]
        state_r <= ST_IDLE;
        osc_r <= '0;
      end else begin
        state_r <= state_nxt;
        osc_r <= osc_nxt;
      end
      addr_r <= '0;
      data_r <= RESET_BYTE;
      rie_r <= 1'b0;
      arm_r <= 3'h0;
      stall_r <= 3'h0;
      rd_pend_r <= 1'b0;
      io_rdata_o <= RESET_BYTE;
      cpu_stall_o <= 1'b0;
      irq_o <= 1'b0;
      arr_addr_o <= '0;
      arr_wdata_o <= RESET_BYTE;
      arr_read_o <= 1'b0;
      arr_erase_o <= 1'b0;
      arr_write_o <= 1'b0;
      arr_busy_o <= (state_r == ST_PROG);
    end else if (ce_i) begin
      state_r <= state_nxt;
      osc_r <= osc_nxt;
      mode_r <= mode_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      rie_r <= rie_nxt;
      arm_r <= arm_nxt;
      stall_r <= stall_nxt;
      rd_pend_r <= rd_pend_nxt;
      io_rdata_o <= rdata_nxt;
      cpu_stall_o <= (stall_nxt != 3'h0);
      irq_o <= irq_nxt;
      arr_addr_o <= addr_nxt;
      arr_wdata_o <= data_nxt;
      arr_read_o <= read_ok; // [RQ14]
      arr_erase_o <= erase_nxt;
      arr_write_o <= write_nxt;
      arr_busy_o <= (state_nxt == ST_PROG);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i || !ce_i);

  property p_arm_expires;
    $rose(arm_r != 3'h0) |-> (arm_r != 3'h0) [*4] ##1 (arm_r == 3'h0);
  endproperty
  a_arm_expires: assert property (p_arm_expires) // [RQ7]
    else $error("arm bit did not clear after four cycles");

  property p_no_start_unarmed;
    (state_r == ST_IDLE && arm_r == 3'h0) |=> (state_r == ST_IDLE);
  endproperty
  a_no_start_unarmed: assert property (p_no_start_unarmed) // [RQ8]
    else $error("program started without arm");

  property p_flash_lock;
    (state_r == ST_IDLE && flash_selfprog_busy_i) |=> (state_r == ST_IDLE);
  endproperty
  a_flash_lock: assert property (p_flash_lock) // [RQ10]
    else $error("program started during flash write");

  property p_wr_stall;
    (state_r == ST_IDLE && start_ok) |=> cpu_stall_o [*2] ##1 !cpu_stall_o;
  endproperty
  a_wr_stall: assert property (p_wr_stall) // [RQ13]
    else $error("write stall not two cycles");

  property p_rd_stall;
    read_ok |=> cpu_stall_o [*4] ##1 !cpu_stall_o;
  endproperty
  a_rd_stall: assert property (p_rd_stall) // [RQ15]
    else $error("read stall not four cycles");

  property p_rd_data;
    read_ok |-> ##2 (data_r == $past(arr_rdata_i));
  endproperty
  a_rd_data: assert property (p_rd_data) // [RQ14]
    else $error("read byte not captured");

  property p_addr_frozen;
    (state_r == ST_PROG) |=> (addr_r == $past(addr_r));
  endproperty
  a_addr_frozen: assert property (p_addr_frozen) // [RQ16]
    else $error("address changed while busy");

  property p_mode_frozen;
    (state_r == ST_PROG) |=> (mode_r == $past(mode_r));
  endproperty
  a_mode_frozen: assert property (p_mode_frozen) // [RQ4]
    else $error("mode changed while busy");

  property p_irq_level;
    irq_o == (rie_r && $past(global_irq_en_i) && state_r == ST_IDLE);
  endproperty
  a_irq_level: assert property (p_irq_level) // [RQ6]
    else $error("ready interrupt missing");

  property p_reserved_mode;
    (mode_r == MODE_RESERVED && state_r == ST_IDLE) |=> !arr_erase_o && !arr_write_o;
  endproperty
  a_reserved_mode: assert property (p_reserved_mode) // [RQ21]
    else $error("reserved mode touched the array");
endmodule : nv_access_ctrl
`default_nettype wire

// File: rtl/nv_access_pkg.sv
// Purpose: shared constants for the nonvolatile byte access controller
// Assumes: 40 MHz cpu clock, byte-wide io register port
// Notes: io offsets are io addresses; data-space alias adds IO_ALIAS
package nv_access_pkg;
  localparam logic [7:0] IO_ALIAS = 8'h20;
  localparam logic [7:0] IO_BIT_TOP = 8'h1f;
  localparam logic [7:0] OFF_CONTROL = 8'h1f;
  localparam logic [7:0] OFF_DATA = 8'h20;
  localparam logic [7:0] OFF_ADDR_LO = 8'h21;
  localparam logic [7:0] OFF_ADDR_HI = 8'h22;
  localparam int ADDR_W = 12;
  localparam int MODE_LSB = 4;
  localparam int RIE_BIT = 3;
  localparam int ARM_BIT = 2;
  localparam int PROG_BIT = 1;
  localparam int READ_BIT = 0;
  localparam logic [1:0] MODE_ATOMIC = 2'h0;
  localparam logic [1:0] MODE_ERASE = 2'h1;
  localparam logic [1:0] MODE_WRITE = 2'h2;
  localparam logic [1:0] MODE_RESERVED = 2'h3;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int CLK_PERIOD_NS = 25;
  localparam int FULL_TIME_US = 3400;
  localparam int SPLIT_TIME_US = 1800;
  localparam int FULL_WRITE_OSC = 26368;
  localparam int OSC_W = 15;
  localparam logic [2:0] ARM_CYCLES = 3'h4;
  localparam logic [2:0] WR_STALL_CYCLES = 3'h2;
  localparam logic [2:0] RD_STALL_CYCLES = 3'h4;
endpackage : nv_access_pkg

// File: testbench/nv_array_model.sv
// Purpose: byte array and rc oscillator facing the access controller
// Assumes: controller pulses are one clk_i cycle wide
// Notes: read byte is true in the read pulse cycle and the next, inverted elsewhere so early capture shows
`timescale 1ns/1ps
`default_nettype none
module nv_array_model (
  input wire logic clk_i, // cpu clock
  input wire logic [11:0] addr_i, // array address
  input wire logic [7:0] wdata_i, // write byte
  input wire logic read_i, // read pulse
  input wire logic erase_i, // erase pulse
  input wire logic write_i, // write pulse
  input wire logic busy_i, // program cycle running
  output logic [7:0] rdata_o, // read byte
  output logic rc_osc_o, // rc oscillator
  output int rc_edges_o // rc edges seen while busy
);
  logic [7:0] mem [0:4095];
  logic rd_q = 1'b0;
  logic osc_q = 1'b0;
  int edges_q = 0;
  // every cell starts at a known pattern so write-only results are predictable
  initial begin
    foreach (mem[i]) mem[i] = 8'ha5;
  end
  // free-running oscillator, phase unrelated to clk_i
  always #31 osc_q = ~osc_q;
  always @(posedge osc_q) if (busy_i) edges_q <= edges_q + 1;
  assign rc_osc_o = osc_q;
  assign rc_edges_o = edges_q;
  // erase gives all ones, write alone can only clear bits
  always @(posedge clk_i) begin
    rd_q <= read_i;
    if (erase_i) mem[addr_i] <= write_i ? wdata_i : 8'hff;
    else if (write_i) mem[addr_i] <= mem[addr_i] & wdata_i;
  end
  assign rdata_o = (read_i | rd_q) ? mem[addr_i] : ~mem[addr_i];
endmodule : nv_array_model
`default_nettype wire

// File: testbench/tb_top.sv
// Purpose: self-checking bench for the nonvolatile access controller
// Assumes: short write count so an erase+write cycle lasts some fifty clocks, erase or write alone half that
// Notes: array contents are checked back through the read strobe
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import nv_access_pkg::*;
  localparam int NW = 20;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] io_addr_i = 8'h00;
  logic io_wr_i = 1'b0;
  logic io_rd_i = 1'b0;
  logic [7:0] io_wdata_i = 8'h00;
  logic bit_set_i = 1'b0;
  logic bit_clr_i = 1'b0;
  logic [2:0] bit_sel_i = 3'h0;
  logic gie = 1'b1;
  logic fbusy = 1'b0;
  logic rc_osc_i, cpu_stall_o, irq_o, arr_read_o, arr_erase_o, arr_write_o, arr_busy_o;
  logic [7:0] arr_rdata_i, io_rdata_o, arr_wdata_o;
  logic [11:0] arr_addr_o;
  int rc_edges;
  int n_errors = 0;
  int checks_done = 0;
  nv_access_ctrl #(.WRITE_OSC_CYCLES(NW)) uut (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1),
    .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i),
    .bit_set_i(bit_set_i), .bit_clr_i(bit_clr_i), .bit_sel_i(bit_sel_i),
    .global_irq_en_i(gie), .flash_selfprog_busy_i(fbusy), .rc_osc_i(rc_osc_i),
    .arr_rdata_i(arr_rdata_i), .io_rdata_o(io_rdata_o), .cpu_stall_o(cpu_stall_o),
    .irq_o(irq_o), .arr_addr_o(arr_addr_o), .arr_wdata_o(arr_wdata_o),
    .arr_read_o(arr_read_o), .arr_erase_o(arr_erase_o), .arr_write_o(arr_write_o),
    .arr_busy_o(arr_busy_o));
  nv_array_model arr (.clk_i(clk_i), .addr_i(arr_addr_o), .wdata_i(arr_wdata_o),
    .read_i(arr_read_o), .erase_i(arr_erase_o), .write_i(arr_write_o),
    .busy_i(arr_busy_o), .rdata_o(arr_rdata_i), .rc_osc_o(rc_osc_i), .rc_edges_o(rc_edges));
  // 40 MHz cpu clock
  always #12.5 clk_i = ~clk_i;
  // inputs move 2 ns after the edge, away from the sampling instant
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_i);
    #2;
  endtask : tick
  // strobes stay up until the next task drives them, so no step lowers and raises one
  task automatic strobe(input logic w, input logic r, input logic s, input logic c);
    io_wr_i = w;
    io_rd_i = r;
    bit_set_i = s;
    bit_clr_i = c;
  endtask : strobe
  task automatic idle(input int n);
    strobe(1'b0, 1'b0, 1'b0, 1'b0);
    tick(n);
  endtask : idle
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    io_addr_i = a;
    io_wdata_i = d;
    strobe(1'b1, 1'b0, 1'b0, 1'b0);
    tick();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    io_addr_i = a;
    strobe(1'b0, 1'b1, 1'b0, 1'b0);
    tick();
    d = io_rdata_o;
  endtask : rd
  task automatic sbit(input logic [2:0] b, input logic clr = 1'b0);
    io_addr_i = OFF_CONTROL;
    bit_sel_i = b;
    strobe(1'b0, 1'b0, !clr, clr);
    tick();
  endtask : sbit
  // stall is a level, so count its cycles over a window longer than the longest
  task automatic stalls(input int exp);
    int n;
    n = 0;
    idle(0);
    repeat (6) begin
      n += int'(cpu_stall_o === 1'b1);
      tick();
    end
    chk("stall cycles", 16'(exp), 16'(n));
  endtask : stalls
  task automatic wait_idle();
    logic [7:0] d;
    int k;
    k = 0;
    d = 8'h02;
    while (d[PROG_BIT] !== 1'b0 && k < 3000) begin
      rd(OFF_CONTROL, d);
      k++;
    end
    chk("write finished", 1'b0, d[PROG_BIT]);
  endtask : wait_idle
  task automatic t_regs();
    logic [7:0] d;
    wr(OFF_ADDR_HI, 8'h0f); // reserved bits written zero
    rd(OFF_ADDR_HI + IO_ALIAS, d);
    chk("addr high", 8'h0f, d);
    wr(OFF_ADDR_LO + IO_ALIAS, 8'h5a);
    rd(OFF_ADDR_LO, d);
    chk("addr low", 8'h5a, d);
    chk("addr out", 12'hf5a, arr_addr_o);
    wr(OFF_DATA, 8'h3c);
    rd(OFF_DATA + IO_ALIAS, d);
    chk("data", 8'h3c, d);
    rd(8'h30, d);
    chk("unmapped", 8'h00, d);
    wr(OFF_CONTROL, 8'h08);
    sbit(3'(RIE_BIT), 1'b1);
    rd(OFF_CONTROL, d);
    chk("bit clear", 8'h00, d);
  endtask : t_regs
  task automatic arr_rd(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] d;
    wr(OFF_ADDR_LO, a[7:0]);
    wr(OFF_ADDR_HI, {4'h0, a[11:8]});
    wr(OFF_CONTROL, 8'h01);
    stalls(4);
    rd(OFF_DATA, d);
    chk("array byte", exp, d);
  endtask : arr_rd
  // full write procedure; gap is extra cycles between arming and the strobe
  task automatic prog(input logic [1:0] m, input logic [11:0] a, input logic [7:0] v,
      input logic arm, input int gap, input logic go, input logic [7:0] ev);
    logic [7:0] d;
    int e0;
    int n;
    n = (m == MODE_ATOMIC) ? NW : NW * SPLIT_TIME_US / FULL_TIME_US;
    wait_idle();
    wr(OFF_ADDR_LO, a[7:0]);
    wr(OFF_ADDR_HI, {4'h0, a[11:8]});
    wr(OFF_DATA, v);
    gie = 1'b0; // interrupts off across arm and strobe
    wr(OFF_CONTROL, {2'h0, m, 1'b1, arm, 2'h0});
    if (gap > 0) begin
      idle(gap);
    end
    e0 = rc_edges;
    sbit(3'(PROG_BIT));
    gie = 1'b1;
    stalls(go ? 2 : 0);
    rd(OFF_CONTROL, d);
    chk("busy", go, d[PROG_BIT]);
    if (go) begin
      chk("irq while busy", 1'b0, irq_o);
      wr(OFF_CONTROL, {2'h0, ~m, 4'h8});
      wr(OFF_ADDR_LO, ~a[7:0]);
      rd(OFF_CONTROL, d);
      chk("mode held", m, d[5:4]);
      chk("addr held", a, arr_addr_o);
      wait_idle();
      chk("rc count", 1'b1, (rc_edges - e0) inside {[n - 1:n + 2]});
      tick();
      chk("irq ready", 1'b1, irq_o);
      gie = 1'b0;
      tick(2);
      chk("irq masked", 1'b0, irq_o);
      gie = 1'b1;
    end
    arr_rd(a, ev);
  endtask : prog
  // a running cycle must survive reset, an idle one must drop its mode
  task automatic t_reset();
    logic [7:0] d;
    wr(OFF_CONTROL, 8'h14);
    sbit(3'(PROG_BIT));
    rstn_i = 1'b0;
    idle(2);
    rstn_i = 1'b1;
    chk("busy over reset", 1'b1, arr_busy_o);
    rd(OFF_CONTROL, d);
    chk("mode over reset", MODE_ERASE, d[5:4]);
    wait_idle();
    rstn_i = 1'b0;
    idle(2);
    rstn_i = 1'b1;
    rd(OFF_CONTROL, d);
    chk("mode after reset", MODE_RESET, d[5:4]);
  endtask : t_reset
  task automatic test_done();
    if (n_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  // main sequence
  initial begin
    tick(12);
    rstn_i = 1'b1;
    t_regs();
    prog(MODE_ATOMIC, 12'h123, 8'h5c, 1'b1, 0, 1'b1, 8'h5c);
    prog(MODE_ERASE, 12'h123, 8'h00, 1'b1, 3, 1'b1, 8'hff);
    prog(MODE_WRITE, 12'h123, 8'h96, 1'b1, 0, 1'b1, 8'h96);
    prog(MODE_WRITE, 12'hfff, 8'h0f, 1'b1, 0, 1'b1, 8'h05);
    prog(MODE_ATOMIC, 12'h010, 8'h11, 1'b0, 0, 1'b0, 8'ha5);
    prog(MODE_ATOMIC, 12'h010, 8'h11, 1'b1, 4, 1'b0, 8'ha5);
    prog(MODE_RESERVED, 12'h010, 8'h11, 1'b1, 0, 1'b0, 8'ha5);
    fbusy = 1'b1;
    prog(MODE_ATOMIC, 12'h010, 8'h11, 1'b1, 0, 1'b0, 8'ha5);
    fbusy = 1'b0;
    t_reset();
    test_done();
  end
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (30000) @(posedge clk_i);
    n_errors++;
    test_done();
  end
endmodule : tb_top
`default_nettype wire
